// File: core/flash_host_ctrl.sv
// host-side controller driving a sector-programmed parallel flash over its pins
// Behaviour
// - sector program loads up to 128 words
// - word load: strobe low, gate high
// - next strobe fall within 150 us window
// - upper lines sector, lower lines word index
// - host waits cycle end before next access
// - three command words enable write lock
// - locked: every program starts with prefix
// - six-word code erases whole array
module flash_host_ctrl #(
	parameter int PWR_DELAY_CYC  = flash_host_pkg::PWR_CYC,
	parameter int POLL_LIMIT_CYC = flash_host_pkg::POLL_MAX_CYC,
	parameter bit PROT_AT_RESET  = 1'b0
) (
	input  wire logic                  ref_clk,   // 20 MHz clock
	input  wire logic                  rst,       // synchronous reset
	input  wire logic                  cmdValid,  // command offered
	output logic                       cmdReady,  // idle, command taken
	input  flash_host_pkg::cmd_s       cmd,       // operation and address
	input  wire logic                  wordValid, // sector word offered
	output logic                       wordReady, // sector word taken
	input  flash_host_pkg::word_s      word,      // word index, data, last
	output logic                       rspValid,  // one-cycle completion
	output flash_host_pkg::rsp_s       rsp,       // read data and error
	output logic                       protActive,// write_lock_protection shadow
	output flash_host_pkg::pins_s      flashPins, // flash control, address, data out
	input  wire logic [15:0]           dqIn       // flash data pins in
);

	typedef enum logic [3:0] {
		S_PWR   = 4'b0000,
		S_IDLE  = 4'b0001,
		S_SEQ   = 4'b0010,
		S_WORD  = 4'b0011,
		S_WLOW  = 4'b0100,
		S_WHIGH = 4'b0101,
		S_TOUT  = 4'b0110,
		S_RD    = 4'b0111,
		S_EVAL  = 4'b1000
	} state_e;

	localparam logic [12:0] GAP_GUARD  = 13'(flash_host_pkg::GAP_GUARD_CYC);
	localparam logic [12:0] TOUT_LIM   = 13'(flash_host_pkg::TOUT_CYC);
	localparam logic [12:0] GAP_MAX    = 13'h1FFF;
	localparam logic [3:0]  STROBE_LIM = 4'(flash_host_pkg::STROBE_LOW_CYC);
	localparam logic [3:0]  READ_LIM   = 4'(flash_host_pkg::READ_WAIT_CYC);
	localparam logic [23:0] PWR_LIM    = 24'(PWR_DELAY_CYC);
	localparam logic [23:0] POLL_LIM   = 24'(POLL_LIMIT_CYC);
	localparam logic [7:0]  LAST_IDX   = 8'(flash_host_pkg::SECTOR_WORDS - 1);

	state_e                  state_r;
	flash_host_pkg::op_e     op_r;
	flash_host_pkg::seq_e    seqSel_r;
	logic [2:0]              seqIdx_r;
	logic                    inSeq_r;
	logic [3:0]              cnt_r;
	logic [12:0]             gapCnt_r;
	logic [23:0]             pollCnt_r;
	logic [23:0]             pwrCnt_r;
	logic                    pwrDone_r;
	logic [7:0]              wordCnt_r;
	logic                    lastWord_r;
	logic [8:0]              sector_r;
	logic [15:0]             addr_r;
	logic [15:0]             dq_r;
	logic                    dqOe_r;
	logic                    ceN_r;
	logic                    oeN_r;
	logic                    weN_r;
	logic [15:0]             lastAddr_r;
	logic [15:0]             lastData_r;
	logic [15:0]             rdData_r;
	logic [15:0]             prevRd_r;
	logic                    firstRd_r;
	logic                    rdPoll_r;
	logic [1:0]              idPhase_r;
	logic [15:0]             idWord_r;
	logic                    err_r;
	logic                    prot_r;
	logic                    rspValid_r;
	flash_host_pkg::rsp_s    rsp_r;
	logic [15:0]             dqS1_r;
	logic [15:0]             dqS2_r;
	logic [15:0]             dqS3_r;
	logic                    togStable;
	logic                    dataMatch;
	logic                    pollDone;
	logic                    finish;

	assign cmdReady   = (state_r == S_IDLE);
	assign wordReady  = (state_r == S_WORD) && (gapCnt_r < GAP_GUARD);
	assign rspValid   = rspValid_r;
	assign rsp        = rsp_r;
	assign protActive = prot_r;
	assign flashPins  = '{addr_r, dq_r, dqOe_r, ceN_r, oeN_r, weN_r};

	// busy while toggle bits still alternate between successive reads
	assign togStable = (rdData_r[flash_host_pkg::TOG_LO_BIT] == prevRd_r[flash_host_pkg::TOG_LO_BIT]) &&
		(rdData_r[flash_host_pkg::TOG_HI_BIT] == prevRd_r[flash_host_pkg::TOG_HI_BIT]);
	assign dataMatch = (rdData_r[flash_host_pkg::POLL_LO_BIT] == lastData_r[flash_host_pkg::POLL_LO_BIT]) &&
		(rdData_r[flash_host_pkg::POLL_HI_BIT] == lastData_r[flash_host_pkg::POLL_HI_BIT]);
	assign pollDone  = !firstRd_r && togStable && (op_r != flash_host_pkg::OP_PROG || err_r || dataMatch);
	assign finish    = (state_r == S_EVAL) && rdPoll_r && pollDone &&
		!(op_r == flash_host_pkg::OP_ID && idPhase_r == 2'h0);

	// pins are asynchronous to ref_clk; a change counts once stages two and three agree
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dqS1_r <= '0;
			dqS2_r <= '0;
			dqS3_r <= '0;
		end else begin
			dqS1_r <= dqIn;
			dqS2_r <= dqS1_r;
			dqS3_r <= dqS2_r;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pwrCnt_r  <= '0;
			pwrDone_r <= 1'b0;
		end else if (!pwrDone_r) begin
			pwrCnt_r  <= pwrCnt_r + 24'h00_0001;
			pwrDone_r <= (pwrCnt_r >= PWR_LIM);
		end
	end

	// time since the last strobe rising edge, saturating
	always_ff @(posedge ref_clk) begin
		if (rst || state_r == S_IDLE || state_r == S_WHIGH) begin
			gapCnt_r <= '0;
		end else if (gapCnt_r != GAP_MAX) begin
			gapCnt_r <= gapCnt_r + 13'h0001;
		end
	end

	// host reset cannot see the device flag, so it starts from a strap value
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prot_r <= PROT_AT_RESET;
		end else if (finish && !err_r && op_r == flash_host_pkg::OP_PROT_ON) begin
			prot_r <= 1'b1;
		end else if (finish && !err_r && op_r == flash_host_pkg::OP_PROT_OFF) begin
			prot_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_r    <= S_PWR;
			op_r       <= flash_host_pkg::OP_READ;
			seqSel_r   <= flash_host_pkg::SEQ_PROTECT;
			seqIdx_r   <= '0;
			inSeq_r    <= 1'b0;
			cnt_r      <= '0;
			pollCnt_r  <= '0;
			wordCnt_r  <= '0;
			lastWord_r <= 1'b0;
			sector_r   <= '0;
			addr_r     <= '0;
			dq_r       <= '0;
			dqOe_r     <= 1'b0;
			ceN_r      <= 1'b1;
			oeN_r      <= 1'b1;
			weN_r      <= 1'b1;
			lastAddr_r <= '0;
			lastData_r <= '0;
			rdData_r   <= '0;
			prevRd_r   <= '0;
			firstRd_r  <= 1'b1;
			rdPoll_r   <= 1'b0;
			idPhase_r  <= '0;
			idWord_r   <= '0;
			err_r      <= 1'b0;
			rspValid_r <= 1'b0;
			rsp_r      <= '0;
		end else begin
			rspValid_r <= 1'b0;
			case (state_r)
				S_PWR: begin
					if (pwrDone_r) begin
						state_r <= S_IDLE;
					end
				end
				S_IDLE: begin
					ceN_r      <= 1'b1;
					oeN_r      <= 1'b1;
					lastWord_r <= 1'b0;
					if (cmdValid) begin
						op_r      <= cmd.op;
						addr_r    <= cmd.addr;
						sector_r  <= cmd.addr[15:7];
						ceN_r     <= 1'b0;
						err_r     <= 1'b0;
						wordCnt_r <= '0;
						pollCnt_r <= '0;
						cnt_r     <= '0;
						idPhase_r <= '0;
						seqIdx_r  <= '0;
						rdPoll_r  <= 1'b0;
						firstRd_r <= 1'b1;
						seqSel_r  <= (cmd.op == flash_host_pkg::OP_PROT_OFF) ? flash_host_pkg::SEQ_UNPROTECT :
							(cmd.op == flash_host_pkg::OP_ERASE) ? flash_host_pkg::SEQ_ERASE :
							(cmd.op == flash_host_pkg::OP_ID) ? flash_host_pkg::SEQ_ID_IN : flash_host_pkg::SEQ_PROTECT;
						// a locked device needs the prefix, else it polls and stores nothing
						inSeq_r   <= (cmd.op != flash_host_pkg::OP_READ) && (cmd.op != flash_host_pkg::OP_PROG || prot_r);
						if (cmd.op == flash_host_pkg::OP_READ) begin
							state_r <= S_RD;
						end else if (cmd.op == flash_host_pkg::OP_PROG && !prot_r) begin
							state_r <= S_WORD;
						end else begin
							state_r <= S_SEQ;
						end
					end
				end
				S_SEQ: begin
					{addr_r, dq_r} <= flash_host_pkg::seq_word(seqSel_r, seqIdx_r);
					dqOe_r         <= 1'b1;
					cnt_r          <= '0;
					state_r        <= S_WLOW;
				end
				S_WORD: begin
					if (gapCnt_r >= GAP_GUARD) begin
						err_r   <= 1'b1;
						state_r <= S_TOUT;
					end else if (wordValid) begin
						addr_r     <= {sector_r, word.idx};
						dq_r       <= word.data;
						lastWord_r <= word.last || (wordCnt_r == LAST_IDX);
						wordCnt_r  <= wordCnt_r + 8'h01;
						dqOe_r     <= 1'b1;
						cnt_r      <= '0;
						state_r    <= S_WLOW;
					end
				end
				S_WLOW: begin
					// strobe held low beyond the noise filter width
					cnt_r <= cnt_r + 4'h1;
					if (cnt_r == STROBE_LIM) begin
						weN_r   <= 1'b1;
						state_r <= S_WHIGH;
					end else begin
						weN_r <= 1'b0;
					end
				end
				S_WHIGH: begin
					dqOe_r     <= 1'b0;
					lastAddr_r <= addr_r;
					lastData_r <= dq_r;
					if (inSeq_r && seqIdx_r != flash_host_pkg::seq_len(seqSel_r) - 3'h1) begin
						seqIdx_r <= seqIdx_r + 3'h1;
						state_r  <= S_SEQ;
					end else if (op_r == flash_host_pkg::OP_PROG && (inSeq_r || !lastWord_r)) begin
						inSeq_r <= 1'b0;
						state_r <= S_WORD;
					end else begin
						inSeq_r <= 1'b0;
						state_r <= S_TOUT;
					end
				end
				S_TOUT: begin
					// let the load window lapse so the device starts its cycle
					if (gapCnt_r >= TOUT_LIM) begin
						addr_r    <= lastAddr_r;
						rdPoll_r  <= 1'b1;
						firstRd_r <= 1'b1;
						cnt_r     <= '0;
						state_r   <= S_RD;
					end
				end
				S_RD: begin
					oeN_r <= 1'b0;
					if (rdPoll_r) begin
						pollCnt_r <= pollCnt_r + 24'h00_0001;
					end
					if (cnt_r < READ_LIM) begin
						cnt_r <= cnt_r + 4'h1;
					end else if (dqS2_r == dqS3_r) begin
						rdData_r <= dqS3_r;
						oeN_r    <= 1'b1;
						state_r  <= S_EVAL;
					end
				end
				S_EVAL: begin
					cnt_r    <= '0;
					prevRd_r <= rdData_r;
					if (rdPoll_r) begin
						pollCnt_r <= pollCnt_r + 24'h00_0001;
						firstRd_r <= 1'b0;
						if (pollDone && op_r == flash_host_pkg::OP_ID && idPhase_r == 2'h0) begin
							idPhase_r <= 2'h1;
							rdPoll_r  <= 1'b0;
							addr_r    <= flash_host_pkg::ID_MFG_ADDR;
							state_r   <= S_RD;
						end else if (pollDone || pollCnt_r >= POLL_LIM) begin
							rspValid_r <= 1'b1;
							rsp_r      <= '{(op_r == flash_host_pkg::OP_ID) ? idWord_r : rdData_r, err_r || !pollDone};
							state_r    <= S_IDLE;
						end else begin
							state_r <= S_RD;
						end
					end else if (op_r == flash_host_pkg::OP_ID) begin
						if (addr_r == flash_host_pkg::ID_MFG_ADDR) begin
							idWord_r[7:0] <= rdData_r[7:0];
							addr_r        <= flash_host_pkg::ID_DEV_ADDR;
							state_r       <= S_RD;
						end else begin
							idWord_r[15:8] <= rdData_r[7:0];
							idPhase_r      <= 2'h2;
							seqSel_r       <= flash_host_pkg::SEQ_ID_OUT;
							seqIdx_r       <= '0;
							inSeq_r        <= 1'b1;
							state_r        <= S_SEQ;
						end
					end else begin
						rspValid_r <= 1'b1;
						rsp_r      <= '{rdData_r, 1'b0};
						state_r    <= S_IDLE;
					end
				end
				default: begin
					state_r <= S_IDLE;
				end
			endcase
		end
	end

	a_no_contention: assert property (@(posedge ref_clk) disable iff (rst)
		flashPins.dqOe |-> flashPins.oeN && !flashPins.ceN)
		else $error("data driven while output gate low or chip idle");

	a_strobe_width: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(flashPins.weN) |-> !flashPins.weN ##1 !flashPins.weN ##1 flashPins.weN)
		else $error("write strobe low width wrong");

	a_load_stable: assert property (@(posedge ref_clk) disable iff (rst)
		(!flashPins.weN && !$fell(flashPins.weN)) |-> $stable(flashPins.addr) && $stable(flashPins.dqOut) && flashPins.dqOe)
		else $error("address or data moved under a low strobe");

	a_sector_fixed: assert property (@(posedge ref_clk) disable iff (rst)
		($fell(flashPins.weN) && op_r == flash_host_pkg::OP_PROG && !inSeq_r) |-> flashPins.addr[15:7] == sector_r)
		else $error("sector changed inside a load period");

	a_load_window: assert property (@(posedge ref_clk) disable iff (rst)
		(state_r == S_WORD && wordValid && wordReady) |=> ##1 !flashPins.weN && gapCnt_r < TOUT_LIM)
		else $error("word strobe outside the load window");

	a_tout_wait: assert property (@(posedge ref_clk) disable iff (rst)
		(state_r == S_TOUT && gapCnt_r < TOUT_LIM) |=> state_r == S_TOUT && flashPins.weN)
		else $error("polling began before the load window lapsed");

	a_power_hold: assert property (@(posedge ref_clk) disable iff (rst)
		!pwrDone_r |-> flashPins.weN && flashPins.ceN && cmdReady == 1'b0)
		else $error("flash touched during power-on delay");

	a_prefix_first: assert property (@(posedge ref_clk) disable iff (rst)
		(state_r == S_IDLE && cmdValid && cmd.op == flash_host_pkg::OP_PROG && prot_r) |=> state_r == S_SEQ ##1
		flashPins.addr == flash_host_pkg::UNLOCK_ADDR1 && flashPins.dqOut == flash_host_pkg::UNLOCK_DATA1)
		else $error("locked program did not open with the prefix");

	a_sector_count: assert property (@(posedge ref_clk) disable iff (rst)
		(state_r == S_WHIGH && op_r == flash_host_pkg::OP_PROG && !inSeq_r && wordCnt_r > LAST_IDX) |=> state_r == S_TOUT)
		else $error("more than a sector of words loaded");

	a_done_stable: assert property (@(posedge ref_clk) disable iff (rst)
		(rspValid && $past(rdPoll_r) && !rsp.err) |-> $past(togStable) && !$past(firstRd_r))
		else $error("completion reported while toggle bits moved");

endmodule : flash_host_ctrl

// File: core/flash_host_pkg.sv
// constants, types and command tables for the parallel flash host controller
package flash_host_pkg;

	localparam int CLK_MHZ        = 20;
	localparam int CLK_NS         = 50;
	localparam int LOAD_WIN_US    = 150;
	localparam int LOAD_WIN_CYC   = LOAD_WIN_US * CLK_MHZ;
	localparam int GAP_MARGIN_CYC = 16;
	localparam int GAP_GUARD_CYC  = LOAD_WIN_CYC - GAP_MARGIN_CYC;
	localparam int TOUT_CYC       = LOAD_WIN_CYC + GAP_MARGIN_CYC;
	localparam int FILTER_NS      = 15;
	localparam int FILTER_CYC     = (FILTER_NS + CLK_NS - 1) / CLK_NS;
	localparam int STROBE_LOW_CYC = FILTER_CYC + 1;
	localparam int ACCESS_NS      = 150;
	localparam int ACCESS_CYC     = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
	localparam int SYNC_CYC       = 3;
	localparam int READ_WAIT_CYC  = ACCESS_CYC + SYNC_CYC;
	localparam int PWR_MS         = 5;
	localparam int PWR_CYC        = PWR_MS * 1000 * CLK_MHZ;
	// bound on program_cycle_time while polling
	localparam int PROG_CYCLE_MS  = 10;
	localparam int POLL_MAX_CYC   = PROG_CYCLE_MS * 1000 * CLK_MHZ;

	localparam int SECTOR_WORDS = 128;
	localparam int WORD_BITS    = 7;
	localparam int ADDR_W       = 16;
	localparam int DATA_W       = 16;
	localparam int POLL_LO_BIT  = 7;
	localparam int POLL_HI_BIT  = 15;
	localparam int TOG_LO_BIT   = 6;
	localparam int TOG_HI_BIT   = 14;

	localparam logic [ADDR_W-1:0] UNLOCK_ADDR1  = 16'h5555;
	localparam logic [ADDR_W-1:0] UNLOCK_ADDR2  = 16'h2AAA;
	localparam logic [DATA_W-1:0] UNLOCK_DATA1  = 16'h00AA;
	localparam logic [DATA_W-1:0] UNLOCK_DATA2  = 16'h0055;
	localparam logic [DATA_W-1:0] CMD_PROTECT   = 16'h00A0;
	localparam logic [DATA_W-1:0] CMD_SETUP     = 16'h0080;
	localparam logic [DATA_W-1:0] CMD_UNPROTECT = 16'h0020;
	localparam logic [DATA_W-1:0] CMD_ERASE     = 16'h0010;
	localparam logic [DATA_W-1:0] CMD_ID_ENTRY  = 16'h0090;
	localparam logic [DATA_W-1:0] CMD_ID_EXIT   = 16'h00F0;
	localparam logic [ADDR_W-1:0] ID_MFG_ADDR   = 16'h0000;
	localparam logic [ADDR_W-1:0] ID_DEV_ADDR   = 16'h0001;
	localparam logic [2:0]        SEQ_SHORT     = 3'h3;
	localparam logic [2:0]        SEQ_LONG      = 3'h6;

	typedef enum logic [2:0] {
		OP_READ     = 3'b000,
		OP_PROG     = 3'b001,
		OP_PROT_ON  = 3'b010,
		OP_PROT_OFF = 3'b011,
		OP_ERASE    = 3'b100,
		OP_ID       = 3'b101
	} op_e;

	typedef enum logic [2:0] {
		SEQ_PROTECT   = 3'b000,
		SEQ_UNPROTECT = 3'b001,
		SEQ_ERASE     = 3'b010,
		SEQ_ID_IN     = 3'b011,
		SEQ_ID_OUT    = 3'b100
	} seq_e;

	typedef struct packed {
		op_e               op;
		logic [ADDR_W-1:0] addr;
	} cmd_s;

	typedef struct packed {
		logic [WORD_BITS-1:0] idx;
		logic [DATA_W-1:0]    data;
		logic                 last;
	} word_s;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic              err;
	} rsp_s;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} bus_word_s;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dqOut;
		logic              dqOe;
		logic              ceN;
		logic              oeN;
		logic              weN;
	} pins_s;

	function automatic logic [2:0] seq_len(seq_e s);
		seq_len = (s == SEQ_UNPROTECT || s == SEQ_ERASE) ? SEQ_LONG : SEQ_SHORT;
	endfunction : seq_len

	function automatic bus_word_s seq_word(seq_e s, logic [2:0] i);
		logic [DATA_W-1:0] third;
		logic [DATA_W-1:0] sixth;
		third = (s == SEQ_PROTECT) ? CMD_PROTECT : (s == SEQ_ID_IN) ? CMD_ID_ENTRY :
			(s == SEQ_ID_OUT) ? CMD_ID_EXIT : CMD_SETUP;
		sixth = (s == SEQ_UNPROTECT) ? CMD_UNPROTECT : CMD_ERASE;
		case (i)
			3'h0:    seq_word = '{UNLOCK_ADDR1, UNLOCK_DATA1};
			3'h1:    seq_word = '{UNLOCK_ADDR2, UNLOCK_DATA2};
			3'h2:    seq_word = '{UNLOCK_ADDR1, third};
			3'h3:    seq_word = '{UNLOCK_ADDR1, UNLOCK_DATA1};
			3'h4:    seq_word = '{UNLOCK_ADDR2, UNLOCK_DATA2};
			default: seq_word = '{UNLOCK_ADDR1, sixth};
		endcase
	endfunction : seq_word

endpackage : flash_host_pkg

// File: bench/flash_dev_model.sv
// behavioural sector flash device on the far side of the host pins
module flash_dev_model #(
	parameter int         CYCLE_NS = 20000, // program_cycle_time, shortened
	parameter int         PWR_NS = 400,   // power-on program block, shortened
	parameter logic [7:0] MFG_ID = 8'h3C, // arbitrary value
	parameter logic [7:0] DEV_ID = 8'h5A  // arbitrary value
) (
	input  flash_host_pkg::pins_s flashPins, // host-driven pins
	output logic [15:0]           dqIn       // data pins seen by host
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem [0:65535];
	logic [15:0] ldA [$];
	logic [15:0] ldD [$];
	logic [15:0] curA;
	logic [15:0] lastD;
	logic [15:0] rdV;
	logic [15:0] relV   = 16'h0000;
	logic        locked = 1'b0; // survives host resets, like a supply cycle
	logic        idMode = 1'b0;
	logic        busy   = 1'b0;
	logic        tog    = 1'b0;
	time         fallT  = 0;
	time         riseT  = 0;
	wire         drv    = !flashPins.ceN && !flashPins.oeN && flashPins.weN;

	initial for (int i = 0; i < 65536; i++) mem[i] = 16'hFFFF;

	always @(negedge flashPins.weN or negedge flashPins.ceN)
		if (!flashPins.weN && !flashPins.ceN) begin
			curA = flashPins.addr;
			fallT = $time;
		end

	always @(posedge flashPins.weN or posedge flashPins.ceN)
		if ((flashPins.weN ^ flashPins.ceN) && flashPins.oeN && !busy
				&& $time - fallT >= 15 && $time >= PWR_NS) begin
			ldA.push_back(curA);
			ldD.push_back(flashPins.dqOut);
			lastD = flashPins.dqOut;
			riseT = $time;
		end

	function automatic bit hit(int i, logic [15:0] a, logic [15:0] d);
		return ldA[i] === a && ldD[i] === d;
	endfunction : hit

	task automatic end_load();
		int n;
		int s;
		bit pre;
		n = ldA.size();
		pre = n >= 3 && hit(0, 16'h5555, 16'h00AA) && hit(1, 16'h2AAA, 16'h0055);
		s = (pre && ldD[2] === 16'h00A0) ? 3 : 0;
		if (pre && n == 3 && ldD[2] === 16'h0090)
			idMode = 1'b1;
		else if (pre && n == 3 && ldD[2] === 16'h00F0)
			idMode = 1'b0;
		else begin
			if (s == 3)
				locked = 1'b1;
			if (pre && n == 6 && ldD[5] === 16'h0020)
				locked = 1'b0;
			else if (pre && n == 6 && ldD[5] === 16'h0010)
				for (int i = 0; i < 65536; i++) mem[i] = 16'hFFFF;
			else if (n > s && (s == 3 || !locked)) begin
				for (int i = 0; i < 128; i++) mem[{ldA[n-1][15:7], 7'(i)}] = 16'hFFFF;
				for (int i = s; i < n; i++) mem[ldA[i]] = ldD[i];
			end
			busy = 1'b1;
			busy <= #(CYCLE_NS) 1'b0;
		end
		ldA.delete();
		ldD.delete();
	endtask : end_load

	initial forever begin
		#50;
		if (ldA.size() > 0 && $time - riseT > 150000)
			end_load();
	end

	always @(negedge flashPins.oeN)
		if (busy)
			tog = ~tog;

	always @* begin
		if (busy)
			rdV = {~lastD[15], tog, lastD[13:8], ~lastD[7], tog, lastD[5:0]};
		else if (idMode && flashPins.addr < 2)
			rdV = flashPins.addr[0] ? {8'h00, DEV_ID} : {8'h00, MFG_ID};
		else
			rdV = mem[flashPins.addr];
	end

	// released pins must not keep the last word, or a stuck read would pass
	always @(negedge drv)
		relV = ~rdV;
	assign dqIn = drv ? rdV : relV;
endmodule : flash_dev_model

// File: bench/tb_sector_flash_program_control.sv
// self-checking bench for the sector flash host controller
module tb_sector_flash_program_control;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int         PWR = 20;
	localparam logic [7:0] MFG = 8'h3C; // arbitrary value
	localparam logic [7:0] DEV = 8'h5A; // arbitrary value
	logic                  ref_clk   = 1'b0;
	logic                  rst       = 1'b1;
	logic                  cmdValid  = 1'b0;
	logic                  wordValid = 1'b0;
	flash_host_pkg::cmd_s  cmd       = '0;
	flash_host_pkg::word_s word      = '0;
	logic                  cmdReady;
	logic                  wordReady;
	logic                  rspValid;
	logic                  protActive;
	flash_host_pkg::rsp_s  rsp;
	flash_host_pkg::pins_s flashPins;
	logic [15:0]           dqIn;
	logic [15:0]           img [0:127];
	logic [6:0]            wIdx [0:127];
	logic [8:0]            sec;
	int                    failures    = 0;
	int                    checks_done = 0;

	always #25 ref_clk = ~ref_clk;

	flash_host_ctrl #(.PWR_DELAY_CYC(PWR), .POLL_LIMIT_CYC(500), .PROT_AT_RESET(1'b0)) uut (
		.ref_clk(ref_clk), .rst(rst), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmd(cmd),
		.wordValid(wordValid), .wordReady(wordReady), .word(word), .rspValid(rspValid), .rsp(rsp),
		.protActive(protActive), .flashPins(flashPins), .dqIn(dqIn));
	flash_dev_model #(.MFG_ID(MFG), .DEV_ID(DEV)) dev (.flashPins(flashPins), .dqIn(dqIn));

	task automatic chk16(logic [15:0] got, logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t data %h expected %h", $time, got, exp);
		end
	endtask : chk16

	task automatic chk1(logic got, logic exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t flag %b expected %b", $time, got, exp);
		end
	endtask : chk1

	task automatic complete_run();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run

	task automatic send(flash_host_pkg::op_e op, logic [15:0] a);
		int n;
		cmd <= '{op, a};
		cmdValid <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (!cmdReady && n < 200);
		cmdValid <= 1'b0;
		if (cmdReady !== 1'b1) begin
			failures++;
			$display("[ERR] %0t command not taken", $time);
		end
	endtask : send

	task automatic wait_rsp();
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (!rspValid && n < 20000);
		if (rspValid !== 1'b1) begin
			failures++;
			$display("[ERR] %0t no response", $time);
		end
	endtask : wait_rsp

	task automatic run(flash_host_pkg::op_e op);
		send(op, 16'h0000);
		wait_rsp();
		chk1(rsp.err, 1'b0);
	endtask : run

	task automatic verify();
		for (int i = 0; i < 128; i++) begin
			send(flash_host_pkg::OP_READ, {sec, 7'(i)});
			wait_rsp();
			chk16(rsp.data, img[i]);
		end
	endtask : verify

	// upd clear: device is expected to ignore the load, so the image stays
	task automatic prog(int cnt, bit drop, bit upd);
		int n;
		int j;
		logic [6:0] t;
		logic [15:0] d;
		for (int i = 127; i > 0; i--) begin
			j = $urandom_range(i);
			t = wIdx[i];
			wIdx[i] = wIdx[j];
			wIdx[j] = t;
		end
		if (upd)
			for (int i = 0; i < 128; i++) img[i] = 16'hFFFF;
		send(flash_host_pkg::OP_PROG, {sec, 7'h00});
		wordValid <= 1'b1;
		for (int i = 0; i < cnt; i++) begin
			d = 16'($urandom);
			word <= '{wIdx[i], d, (i == cnt - 1) && !drop};
			n = 0;
			do begin
				@(posedge ref_clk);
				n++;
			end while (!wordReady && n < 100);
			if (wordReady !== 1'b1) begin
				failures++;
				$display("[ERR] %0t word not taken", $time);
			end
			if (upd)
				img[wIdx[i]] = d;
		end
		wordValid <= 1'b0;
		wait_rsp();
	endtask : prog

	always @(negedge ref_clk)
		if (!rst && (!flashPins.weN || flashPins.dqOe))
			chk1(flashPins.oeN, 1'b1);

	initial begin
		#(100000 * 50);
		failures++;
		$display("[ERR] %0t watchdog expired", $time);
		complete_run();
	end

	initial begin
		void'($urandom(26794));
		for (int i = 0; i < 128; i++) wIdx[i] = 7'(i);
		sec = 9'h100 + 9'($urandom_range(255));
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (PWR) @(posedge ref_clk);
		chk1(cmdReady, 1'b0);
		chk1(flashPins.ceN, 1'b1);
		prog(128, 1'b0, 1'b1);
		chk1(rsp.err, 1'b0);
		verify();
		prog(5, 1'b0, 1'b1);
		verify();
		prog(1, 1'b1, 1'b1);
		chk1(rsp.err, 1'b1);
		verify();
		run(flash_host_pkg::OP_PROT_ON);
		chk1(protActive, 1'b1);
		prog(3, 1'b0, 1'b1);
		verify();
		rst <= 1'b1;
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		chk1(protActive, 1'b0);
		prog(2, 1'b0, 1'b0);
		verify();
		run(flash_host_pkg::OP_PROT_OFF);
		prog(4, 1'b0, 1'b1);
		verify();
		run(flash_host_pkg::OP_ID);
		chk16(rsp.data, {DEV, MFG});
		run(flash_host_pkg::OP_ERASE);
		for (int i = 0; i < 128; i++) img[i] = 16'hFFFF;
		verify();
		complete_run();
	end
endmodule : tb_sector_flash_program_control
